// File: lfb_top.v
/*
 LCD frame and booster clock generator with a Wishbone classic slave.
 Assumes clk_i is the high-frequency clock and low_freq_clock_i is an
 asynchronous low-frequency clock pin; clock-mode inputs are on clk_i.
*/
// Decided for this implementation: the register addresses and the Wishbone register port.
// What this block does
// - Four drive methods are offered and chosen by a software-written field.
// - On the fast clock the frame base is that clock over 2^17/2^16/2^15/2^13.
// - On the slow clock the frame base is that clock over 2^9 or 2^8.
// - Frame rate is base for 1/4 and static, 4/3 base for 1/3, 2x for 1/2.
// - Booster enable 1 uses the internal booster, 0 the external divider.
// - Boost clock is fast over 2^13/2^11/2^10/2^9, or slow over 2^5/2^3/2^2.
`timescale 1ns/100ps
`include "lfb_regs.vh"
module lfb_top (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire low_freq_clock_i,
  input wire dual_clock_mode_i,
  input wire prescaler_source_select_i,
  input wire system_clock_select_i,
  output reg base_tick_o,
  output reg frame_tick_o,
  output reg boost_tick_o,
  output reg [1:0] drive_method_o,
  output reg display_enable_o,
  output reg voltage_booster_enable_o,
  output reg ext_divider_select_o
);

  ////////////////////////////////////////////////////////////////////////
  // Register file
  reg [7:0] lcd_control_reg;
  reg fs_sync1;
  reg fs_sync2;
  reg fs_sync3;
  reg [1:0] third_count;
  reg [1:0] next_third_count;
  reg next_base;
  reg next_frame;
  reg next_boost;
  reg [4:0] base_exp;
  reg [4:0] boost_exp;
  reg boost_on_fast;
  wire [1:0] frame_base_select;
  wire [1:0] boost_freq_select;
  wire [1:0] duty;
  wire use_low;
  wire fs_rise;
  wire [`LFB_FC_STAGES-1:0] fc_taps;
  wire [`LFB_FS_STAGES-1:0] fs_taps;
  wire [`LFB_FC_STAGES-1:0] fs_wide;
  wire [`LFB_FC_STAGES-1:0] base_taps;
  wire [`LFB_FC_STAGES-1:0] boost_taps;
  wire bus_req;

  // Pick one divider stage by its exponent
  function tap;
    input [`LFB_FC_STAGES-1:0] v;
    input [4:0] e;
    begin
      tap = v[e - 5'h01];
    end
  endfunction

  assign frame_base_select = lcd_control_reg[`LFB_FBASE_HI:`LFB_FBASE_LO];
  assign boost_freq_select = lcd_control_reg[`LFB_BFREQ_HI:`LFB_BFREQ_LO];
  assign duty = lcd_control_reg[`LFB_DUTY_HI:`LFB_DUTY_LO];
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always @(posedge clk_i) begin
    if (rst_i) begin
      lcd_control_reg <= `LFB_CTRL_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      // Write lands on the edge where the master sees ack
      if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
        wb_adr_i == `LFB_CTRL_ADDR) begin
        lcd_control_reg <= wb_dat_i[7:0];
      end
      if (bus_req) begin
        if (wb_adr_i == `LFB_CTRL_ADDR) begin
          wb_dat_o <= {24'h000000, lcd_control_reg};
        end else if (wb_adr_i == `LFB_STAT_ADDR) begin
          wb_dat_o <= {29'h00000000, fs_sync2, use_low, boost_on_fast};
        end else begin
          wb_dat_o <= 32'h00000000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Low-frequency clock pin synchroniser and divider chains
  always @(posedge clk_i) begin
    if (rst_i) begin
      fs_sync1 <= 1'b0;
      fs_sync2 <= 1'b0;
      fs_sync3 <= 1'b0;
    end else begin
      fs_sync1 <= low_freq_clock_i;
      fs_sync2 <= fs_sync1;
      fs_sync3 <= fs_sync2;
    end
  end

  assign fs_rise = fs_sync2 & ~fs_sync3;
  assign use_low = system_clock_select_i |
    (dual_clock_mode_i & prescaler_source_select_i);

  lfb_divider #(
    .WIDTH(`LFB_FC_STAGES)
  ) u_fc_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(1'b1),
    .taps_o(fc_taps)
  );

  lfb_divider #(
    .WIDTH(`LFB_FS_STAGES)
  ) u_fs_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(fs_rise),
    .taps_o(fs_taps)
  );

  assign fs_wide = {{(`LFB_FC_STAGES-`LFB_FS_STAGES){1'b0}}, fs_taps};
  assign base_taps = use_low ? fs_wide : fc_taps;
  assign boost_taps = boost_on_fast ? fc_taps : fs_wide;

  ////////////////////////////////////////////////////////////////////////
  // Frame base, frame rate and booster clock selection
  always @* begin
    if (use_low) begin
      if (frame_base_select[0]) begin
        base_exp = `LFB_FS_BASE_1;
      end else begin
        base_exp = `LFB_FS_BASE_0;
      end
    end else begin
      case (frame_base_select)
        2'h0: base_exp = `LFB_FC_BASE_0;
        2'h1: base_exp = `LFB_FC_BASE_1;
        2'h2: base_exp = `LFB_FC_BASE_2;
        default: base_exp = `LFB_FC_BASE_3;
      endcase
    end
    boost_on_fast = ~use_low | (boost_freq_select == 2'h3);
    if (boost_on_fast) begin
      case (boost_freq_select)
        2'h0: boost_exp = `LFB_FC_BOOST_0;
        2'h1: boost_exp = `LFB_FC_BOOST_1;
        2'h2: boost_exp = `LFB_FC_BOOST_2;
        default: boost_exp = `LFB_FC_BOOST_3;
      endcase
    end else begin
      case (boost_freq_select)
        2'h0: boost_exp = `LFB_FS_BOOST_0;
        2'h1: boost_exp = `LFB_FS_BOOST_1;
        default: boost_exp = `LFB_FS_BOOST_2;
      endcase
    end
    next_base = tap(base_taps, base_exp);
    next_boost = tap(boost_taps, boost_exp);
    next_third_count = third_count;
    next_frame = 1'b0;
    case (duty)
      `LFB_DUTY_THIRD: begin
        // 4/3 of base: a quarter-period stage divided by three
        if (tap(base_taps, base_exp - 5'h01 - 5'h01)) begin
          if (third_count == 2'h2) begin
            next_third_count = 2'h0;
            next_frame = 1'b1;
          end else begin
            next_third_count = third_count + 2'h1;
          end
        end
      end
      `LFB_DUTY_HALF: next_frame = tap(base_taps, base_exp - 5'h01);
      default: next_frame = next_base;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      third_count <= 2'h0;
      base_tick_o <= 1'b0;
      frame_tick_o <= 1'b0;
      boost_tick_o <= 1'b0;
      drive_method_o <= `LFB_DUTY_QUARTER;
      display_enable_o <= 1'b0;
      voltage_booster_enable_o <= 1'b0;
      ext_divider_select_o <= 1'b1;
    end else begin
      third_count <= next_third_count;
      base_tick_o <= next_base;
      frame_tick_o <= next_frame;
      boost_tick_o <= next_boost & lcd_control_reg[`LFB_BOOST_EN_BIT];
      drive_method_o <= duty;
      display_enable_o <= lcd_control_reg[`LFB_DISP_BIT];
      voltage_booster_enable_o <= lcd_control_reg[`LFB_BOOST_EN_BIT];
      ext_divider_select_o <= ~lcd_control_reg[`LFB_BOOST_EN_BIT];
    end
  end

endmodule

// File: lfb_regs.vh
/*
 Constants of the LCD frame and booster clock generator: register
 offsets, field positions, reset value and divider exponents.
 Assumes a byte-addressed Wishbone bus with 32-bit aligned words.
*/
`ifndef LFB_REGS_VH
`define LFB_REGS_VH

// Register byte offsets
`define LFB_CTRL_ADDR 8'h00
`define LFB_STAT_ADDR 8'h04

// Control register fields
`define LFB_DISP_BIT 7
`define LFB_BOOST_EN_BIT 6
`define LFB_BFREQ_HI 5
`define LFB_BFREQ_LO 4
`define LFB_DUTY_HI 3
`define LFB_DUTY_LO 2
`define LFB_FBASE_HI 1
`define LFB_FBASE_LO 0
`define LFB_CTRL_RESET 8'h00

// Drive method codes
`define LFB_DUTY_QUARTER 2'h0
`define LFB_DUTY_THIRD 2'h1
`define LFB_DUTY_HALF 2'h2
`define LFB_DUTY_STATIC 2'h3

// Frame base exponents, high-frequency clock
`define LFB_FC_BASE_0 5'h11
`define LFB_FC_BASE_1 5'h10
`define LFB_FC_BASE_2 5'h0F
`define LFB_FC_BASE_3 5'h0D
// Frame base exponents, low-frequency clock
`define LFB_FS_BASE_0 5'h09
`define LFB_FS_BASE_1 5'h08

// Booster exponents, high-frequency clock
`define LFB_FC_BOOST_0 5'h0D
`define LFB_FC_BOOST_1 5'h0B
`define LFB_FC_BOOST_2 5'h0A
`define LFB_FC_BOOST_3 5'h09
// Booster exponents, low-frequency clock
`define LFB_FS_BOOST_0 5'h05
`define LFB_FS_BOOST_1 5'h03
`define LFB_FS_BOOST_2 5'h02

// Divider chain lengths
`define LFB_FC_STAGES 17
`define LFB_FS_STAGES 9

`endif

// File: lfb_divider.v
/*
 Power-of-two divider chain: one output pulse per stage.
 Assumes tick_i is a one-cycle enable on clk_i.
*/
`timescale 1ns/100ps
module lfb_divider #(
  parameter WIDTH = 17
) (
  input wire clk_i,
  input wire rst_i,
  input wire tick_i,
  output wire [WIDTH-1:0] taps_o
);

  reg [WIDTH-1:0] count;

  always @(posedge clk_i) begin
    if (rst_i) begin
      count <= {WIDTH{1'b0}};
    end else if (tick_i) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Bit k pulses once every 2^(k+1) ticks
  genvar k;
  generate
    for (k = 0; k < WIDTH; k = k + 1) begin : g_tap
      assign taps_o[k] = tick_i & (&count[k:0]);
    end
  endgenerate

endmodule

// File: lfb_checker.sv
/* Port checker for lfb_top.
 Assumes one clock clk_i and synchronous active-high rst_i. */
`timescale 1ns/100ps
module lfb_checker (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [31:0] wb_dat_o,
  input wire base_tick_o,
  input wire frame_tick_o,
  input wire boost_tick_o,
  input wire [1:0] drive_method_o,
  input wire voltage_booster_enable_o,
  input wire ext_divider_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_quiet;
    !frame_tick_o && !wb_ack_o && drive_method_o == 2'h0;
  endsequence
  a_ack_after_req:
    assert property (s_req |=> wb_ack_o) else $error("ack late");
  a_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  a_upper_zero:
    assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper bits set");
  a_boost_excl:
    assert property (voltage_booster_enable_o != ext_divider_select_o)
    else $error("booster and divider");
  a_boost_gate:
    assert property (boost_tick_o |-> voltage_booster_enable_o)
    else $error("boost tick while off");
  a_frame_eq_base:
    assert property (base_tick_o && drive_method_o[0] == drive_method_o[1]
      && $stable(drive_method_o) |-> frame_tick_o) else $error("frame rate");
  a_frame_pulse:
    assert property (frame_tick_o |=> !frame_tick_o) else $error("tick long");
  a_reset_vals:
    assert property (disable iff (1'b0) rst_i |=> (s_quiet
      and ext_divider_select_o)) else $error("reset values");
endmodule
////////////////////////////////////////////////////////////
bind lfb_top lfb_checker chk (.*);

// File: tb.sv
/* Self-checking bench for lfb_top.
 Assumes the checker is bound in from its own file. */
`timescale 1ns/100ps
module tb;
  reg clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0, low_freq_clock_i = 1'b0, dual_clock_mode_i = 1'b0;
  reg prescaler_source_select_i = 1'b0, system_clock_select_i = 1'b0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [3:0] wb_sel_i = 4'hF;
  reg [31:0] wb_dat_i = 32'h0, rd;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, base_tick_o, frame_tick_o, boost_tick_o;
  wire display_enable_o, voltage_booster_enable_o, ext_divider_select_o;
  wire [1:0] drive_method_o;
  integer miscompares = 0, comparisons = 0, ctrl = 0, fsc = 0, i, n, k;
  lfb_top dut (.*);
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    fsc <= fsc + 1;
    if (fsc % 10 == 9)
      low_freq_clock_i <= ~low_freq_clock_i;
  end
  ////////////////////////////////////////////////////////////
  task end_sim;
    begin
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && n < 50) begin
        n = n + 1;
        @(posedge clk_i);
      end
      check({31'h0, wb_ack_o}, 32'h1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (w && a == 8'h00 && wb_sel_i[0])
        ctrl = d[7:0];
    end
  endtask
  task setc(input [7:0] v);
    begin
      wb(1'b1, 8'h00, ($urandom << 8) | v);
      wb(1'b0, 8'h00, 32'h0);
      check(rd, ctrl);
      check({display_enable_o, voltage_booster_enable_o, ext_divider_select_o,
        drive_method_o}, {ctrl[7], ctrl[6], ~ctrl[6], ctrl[3:2]});
    end
  endtask
  function tk(input integer s);
    tk = s == 0 ? base_tick_o : s == 1 ? frame_tick_o : boost_tick_o;
  endfunction
  task meas(input integer s, input integer p);
    begin
      for (k = 0; k < 3; k = k + 1) begin
        n = 1;
        @(negedge clk_i);
        while (tk(s) !== 1'b1 && n < 20000) begin
          n = n + 1;
          @(negedge clk_i);
        end
      end
      check(n, p);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #480000;
    miscompares = miscompares + 1;
    end_sim;
  end
  initial begin
    i = $urandom(32'hf96ba96b);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, 8'h08, 32'hFF);
    wb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    wb_sel_i <= 4'hE;
    wb(1'b1, 8'h00, 32'hFF);
    wb_sel_i <= 4'hF;
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    for (i = 0; i < 4; i = i + 1)
      setc({4'h0, i[1:0], 2'h3});
    $display("test regs done");
    for (i = 1; i < 4; i = i + 1) begin
      setc({4'h0, i[1:0], 2'h3});
      meas(1, i == 1 ? 6144 : i == 2 ? 4096 : 8192);
    end
    $display("test frame done");
    for (i = 1; i < 4; i = i + 1) begin
      setc({2'h1, i[1:0], 4'h3});
      meas(2, 8192 >> (i + 1));
    end
    $display("test boost done");
    setc(8'h41);
    system_clock_select_i <= 1'b1;
    wb(1'b0, 8'h04, 32'h0);
    check(rd & 32'hFFFFFFFB, 32'h2);
    meas(0, 5120);
    meas(2, 640);
    system_clock_select_i <= 1'b0;
    dual_clock_mode_i <= 1'b1;
    prescaler_source_select_i <= 1'b1;
    meas(2, 640);
    $display("test slow done");
    end_sim;
  end
endmodule
